/* File: verilog/irc_pkg.sv */
package irc_pkg;

    // ---------------------------------------------------------------
    // Register offsets and reset values
    // ---------------------------------------------------------------
    localparam logic [6:0] OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING = 7'h5f;
    localparam logic [6:0] OFS_SYNC_COMMAND_CODE = 7'h60;
    localparam logic [6:0] OFS_SYNC_DELTA_TIME = 7'h61;
    localparam logic [6:0] OFS_BUS_AVAILABLE_TIME_CFG = 7'h62;
    localparam logic [6:0] OFS_RATE_TRIM_READOUT = 7'h63;
    localparam logic [6:0] OFS_STAB_INTERRUPT_CFG = 7'h6f;
    localparam logic [6:0] OFS_STAB_CONTROL_ONE = 7'h70;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ---------------------------------------------------------------
    // Field positions and writable masks
    // ---------------------------------------------------------------
    localparam int ROUTE_TS_BIT = 0;
    localparam int BUSAVB_PDOFF_BIT = 0;
    localparam int BUSAVB_SEL_LSB = 3;
    localparam logic [7:0] BUSAVB_MASK = 8'h19;
    localparam int SINT_READY_BIT = 7;
    localparam int SINT_LVL2_BIT = 6;
    localparam int SINT_POL_BIT = 5;
    localparam int SINT_RDEN_BIT = 3;
    localparam logic [7:0] SINT_MASK = 8'he8;
    localparam int SCTL_LVL1_BIT = 6;
    localparam int SCTL_WIRE_BIT = 5;
    localparam int SCTL_ACCEL_BIT = 4;
    localparam int SCTL_RANGE_LSB = 2;
    localparam int SCTL_LOW_BIT = 1;
    localparam int SCTL_CHAIN_BIT = 0;
    localparam logic [7:0] SCTL_MASK = 8'h7f;
    localparam logic [6:0] AUX_OUT_FIRST = 7'h22;
    localparam logic [6:0] AUX_OUT_LAST = 7'h2d;

    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int BUS_AVB_2US_NS = 2000;
    localparam int BUS_AVB_2US_CYC = BUS_AVB_2US_NS / CLK_PERIOD_NS;
    localparam int TS_LEAD_NS = 6400000;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [7:0] data;
    } irc_req_s;

    typedef enum logic [2:0] {
        GATE_OFF = 3'b001,
        GATE_TRIG = 3'b010,
        GATE_LATCH = 3'b100
    } irc_gate_e;

    typedef enum logic [4:0] {
        RANGE_125 = 5'b00001,
        RANGE_250 = 5'b00010,
        RANGE_500 = 5'b00100,
        RANGE_1000 = 5'b01000,
        RANGE_2000 = 5'b10000
    } irc_range_e;

endpackage : irc_pkg

/* File: verilog/irc_second_interrupt_pin_stab_regs.sv */
// Operation
// - Seven enable bits route motion events to second pin, all default off.
// - Timestamp alert bit flags counter overflow within lead time on second pin.
// - Eight-bit read/write sync command code, reset zero.
// - Eight-bit read/write sync delta time, reset zero.
// - Two-bit selector picks bus available time: 50us, 2us, 1ms, 25ms.
// - Pull-down off bit disconnects first pin pull-down; otherwise connect conditionally.
// - Read-only signed rate deviation value, 0.15 percent per count.
// - Stabilization registers writable only under primary control, else mirror auxiliary copies.
// - Stabilization ready routing overrides every other second pin setting.
// - Polarity bit selects active-low or active-high data gate input.
// - Under primary control, auxiliary reads of outputs need read enable.
// - Wire-mode bit picks 4-wire (0) or 3-wire (1) auxiliary port.
// - Accelerometer chain runs only when both its enable and chain enable set.
// - Gyro range field selects 250..2000; separate bit overrides to 125.
// - Chain enable starts gyro processing; filter dedicated under primary control.
// - Level bits 10 select trigger mode, 11 select latched mode.
// - Data gate mode applies to gyroscope data only.
// - Activity route reports change or status per external selection bit.
// - Activity mode 00 gives motion interrupts only, rates unchanged.
`timescale 1ns/1ps
module irc_second_interrupt_pin_stab_regs
    import irc_pkg::*;
#(
    parameter int TS_W = 32,
    parameter int TS_TICK_NS = 25000,
    parameter int BUS_AVB_50US_CYC = 12500,
    parameter int BUS_AVB_1MS_CYC = 250000,
    parameter int BUS_AVB_25MS_CYC = 6250000
)
(
    input wire logic clk, // Main clock
    input wire logic rst_n, // Synchronous reset, main domain
    input wire logic auxClk, // Auxiliary port clock
    input wire logic auxRst_n, // Synchronous reset, auxiliary domain
    input wire irc_req_s regReq, // Primary register access
    output logic [7:0] rdData, // Read data
    output logic rdValid, // Read data valid pulse
    input wire logic [5:0] eventIn, // Knock, wakeup, freefall, double, orient, embedded
    input wire logic actChange, // Activity change event
    input wire logic actStatus, // Activity sleep status
    input wire logic sleepStatusSel, // Report status instead of change
    input wire logic [1:0] activityMode, // Configured activity mode
    input wire logic [TS_W-1:0] tsCount, // Timestamp counter
    input wire logic stabDataReady, // Stabilization data ready
    input wire logic primaryCtlFlag, // Stabilization primary control flag
    input wire logic int1RouteAny, // Some interrupt routed to first pin
    input wire logic dynAddrAssigned, // Dynamic address assigned
    input wire logic [7:0] rateTrim, // Rate deviation value
    input wire logic busIdle, // Bus idle level
    input wire logic dataGateIn, // Data gate pin, asynchronous
    input wire logic [7:0] auxIntCfgCopy, // Auxiliary interrupt config copy
    input wire logic [7:0] auxCtrlOneCopy, // Auxiliary control one copy
    input wire logic [6:0] auxRdAddr, // Auxiliary read address
    input wire logic auxRdStrobe, // Auxiliary read request
    output logic secondPinOut, // Second interrupt pin level
    output logic firstPinPulldownOn, // First pin pull-down connected
    output logic busAvailable, // Bus available time elapsed
    output logic [7:0] syncCmd, // Sync command value
    output logic [7:0] syncDelta, // Sync delta value
    output logic gyroGateActive, // Data gate asserted, gyro path
    output irc_gate_e gyroGateMode, // Data gate mode, gyro path
    output logic gyroChainRun, // Gyro stabilization chain running
    output logic accelChainRun, // Accel stabilization chain running
    output logic lpfDedicated, // First low-pass filter given to chain
    output irc_range_e gyroRange, // Gyro stabilization range
    output logic activityRateChange, // Activity function changes rates
    output logic auxWireThree, // Auxiliary port 3-wire, aux domain
    output logic auxRdGrant // Auxiliary read granted, aux domain
);

    // ---------------------------------------------------------------
    // Declarations
    // ---------------------------------------------------------------
    logic [7:0] routingReg;
    logic [7:0] busAvbReg;
    logic [7:0] stabIntReg;
    logic [7:0] stabCtlReg;
    logic [15:0] mirrorReg;
    logic ackTogReg;
    logic reqSync1Reg;
    logic reqSync2Reg;
    logic [15:0] auxHoldReg;
    logic auxTogReg;
    logic ackSync1Reg;
    logic ackSync2Reg;
    logic [2:0] toAux1Reg;
    logic [2:0] toAux2Reg;
    logic gateSync1Reg;
    logic gateSync2Reg;
    logic [22:0] idleCntReg;
    logic [7:0] busAvbNext;

    // ---------------------------------------------------------------
    // Decode and selection
    // ---------------------------------------------------------------
    wire wrRouting = regReq.wr && regReq.addr == OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING;
    wire wrCmd = regReq.wr && regReq.addr == OFS_SYNC_COMMAND_CODE;
    wire wrDelta = regReq.wr && regReq.addr == OFS_SYNC_DELTA_TIME;
    wire wrBusAvb = regReq.wr && regReq.addr == OFS_BUS_AVAILABLE_TIME_CFG;
    // Mirrored registers take writes only under primary control
    wire wrStabInt = regReq.wr && regReq.addr == OFS_STAB_INTERRUPT_CFG
        && primaryCtlFlag;
    wire wrStabCtl = regReq.wr && regReq.addr == OFS_STAB_CONTROL_ONE
        && primaryCtlFlag;
    // Effective stabilization settings: own copy or auxiliary mirror
    wire [7:0] intEff = primaryCtlFlag ? stabIntReg : mirrorReg[15:8];
    wire [7:0] ctlEff = primaryCtlFlag ? stabCtlReg : mirrorReg[7:0];
    wire [7:0] rdMux =
        regReq.addr == OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING ? routingReg :
        regReq.addr == OFS_SYNC_COMMAND_CODE ? syncCmd :
        regReq.addr == OFS_SYNC_DELTA_TIME ? syncDelta :
        regReq.addr == OFS_BUS_AVAILABLE_TIME_CFG ? busAvbReg :
        regReq.addr == OFS_RATE_TRIM_READOUT ? rateTrim :
        regReq.addr == OFS_STAB_INTERRUPT_CFG ? intEff :
        regReq.addr == OFS_STAB_CONTROL_ONE ? ctlEff : REG_RESET;

    // Second pin composition
    localparam int TS_LEAD_TICKS = TS_LEAD_NS / TS_TICK_NS;
    localparam logic [TS_W-1:0] TS_ALERT_AT = {TS_W{1'b1}} - TS_LEAD_TICKS[TS_W-1:0];
    wire tsNear = tsCount >= TS_ALERT_AT;
    wire actSel = sleepStatusSel ? actStatus : actChange;
    wire [6:0] evAll = {actSel, eventIn};
    wire evRouted = |(evAll & routingReg[7:1]);
    wire tsRouted = routingReg[ROUTE_TS_BIT] && tsNear;
    wire int2Next = intEff[SINT_READY_BIT] ? stabDataReady
        : (evRouted || tsRouted);

    // Pull-down connects only with no first pin route or address assigned
    wire pdNext = !busAvbReg[BUSAVB_PDOFF_BIT]
        && (!int1RouteAny || dynAddrAssigned);

    // Bus available time target
    wire [1:0] avbSel = busAvbReg[BUSAVB_SEL_LSB +: 2];
    wire [22:0] avbTarget =
        avbSel == 2'b00 ? BUS_AVB_50US_CYC[22:0] :
        avbSel == 2'b01 ? BUS_AVB_2US_CYC[22:0] :
        avbSel == 2'b10 ? BUS_AVB_1MS_CYC[22:0] : BUS_AVB_25MS_CYC[22:0];
    wire idleDone = idleCntReg >= avbTarget;

    // Data gate and stabilization chain decode
    wire gateLevel = intEff[SINT_POL_BIT] ? gateSync2Reg : !gateSync2Reg;
    wire [1:0] lvlPair = {ctlEff[SCTL_LVL1_BIT], intEff[SINT_LVL2_BIT]};
    wire irc_gate_e gateModeNext = lvlPair == 2'b10 ? GATE_TRIG :
        lvlPair == 2'b11 ? GATE_LATCH : GATE_OFF;
    wire [1:0] rangeField = ctlEff[SCTL_RANGE_LSB +: 2];
    wire irc_range_e rangeNext = ctlEff[SCTL_LOW_BIT] ? RANGE_125 :
        rangeField == 2'b00 ? RANGE_250 :
        rangeField == 2'b01 ? RANGE_500 :
        rangeField == 2'b10 ? RANGE_1000 : RANGE_2000;
    wire chainOn = ctlEff[SCTL_CHAIN_BIT];
    wire accelOn = chainOn && ctlEff[SCTL_ACCEL_BIT];
    wire [2:0] toAuxLevels = {primaryCtlFlag, intEff[SINT_RDEN_BIT],
        ctlEff[SCTL_WIRE_BIT]};

    // Fixed-zero positions are never stored
    assign busAvbNext = regReq.data & BUSAVB_MASK;

    // ---------------------------------------------------------------
    // Primary register file
    // ---------------------------------------------------------------
    // Host-written registers
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            routingReg <= REG_RESET;
            syncCmd <= REG_RESET;
            syncDelta <= REG_RESET;
            busAvbReg <= REG_RESET;
            stabIntReg <= REG_RESET;
            stabCtlReg <= REG_RESET;
        end
        else
        begin
            if (wrRouting) routingReg <= regReq.data;
            if (wrCmd) syncCmd <= regReq.data;
            if (wrDelta) syncDelta <= regReq.data;
            if (wrBusAvb) busAvbReg <= busAvbNext;
            if (wrStabInt) stabIntReg <= regReq.data & SINT_MASK;
            if (wrStabCtl) stabCtlReg <= regReq.data & SCTL_MASK;
        end
    end

    // Read port, one cycle latency, unmapped reads zero
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdData <= REG_RESET;
            rdValid <= 1'b0;
        end
        else
        begin
            rdValid <= regReq.rd;
            if (regReq.rd) rdData <= rdMux;
        end
    end

    // ---------------------------------------------------------------
    // Pin and chain outputs
    // ---------------------------------------------------------------
    // Registered outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            secondPinOut <= 1'b0;
            firstPinPulldownOn <= 1'b0;
            gyroGateActive <= 1'b0;
            gyroGateMode <= GATE_OFF;
            gyroChainRun <= 1'b0;
            accelChainRun <= 1'b0;
            lpfDedicated <= 1'b0;
            gyroRange <= RANGE_250;
            activityRateChange <= 1'b0;
        end
        else
        begin
            secondPinOut <= int2Next;
            firstPinPulldownOn <= pdNext;
            gyroGateActive <= gateLevel;
            gyroGateMode <= gateModeNext;
            gyroChainRun <= chainOn;
            accelChainRun <= accelOn;
            lpfDedicated <= chainOn && primaryCtlFlag;
            gyroRange <= rangeNext;
            activityRateChange <= activityMode != 2'b00;
        end
    end

    // Bus idle counter and available flag
    always_ff @(posedge clk)
    begin
        if (!rst_n || !busIdle)
        begin
            idleCntReg <= '0;
            busAvailable <= 1'b0;
        end
        else
        begin
            if (!idleDone) idleCntReg <= idleCntReg + 23'h000001;
            busAvailable <= idleDone;
        end
    end

    // Data gate pin synchroniser
    always_ff @(posedge clk)
    begin
        gateSync1Reg <= dataGateIn;
        gateSync2Reg <= gateSync1Reg;
    end

    // ---------------------------------------------------------------
    // Mirror crossing, auxiliary copies to main domain
    // ---------------------------------------------------------------
    // Aux side: load a new word only when the previous one is acknowledged
    always_ff @(posedge auxClk)
    begin
        if (!auxRst_n)
        begin
            auxHoldReg <= 16'h0000;
            auxTogReg <= 1'b0;
            ackSync1Reg <= 1'b0;
            ackSync2Reg <= 1'b0;
        end
        else
        begin
            ackSync1Reg <= ackTogReg;
            ackSync2Reg <= ackSync1Reg;
            if (auxTogReg == ackSync2Reg
                && auxHoldReg != {auxIntCfgCopy, auxCtrlOneCopy})
            begin
                auxHoldReg <= {auxIntCfgCopy, auxCtrlOneCopy};
                auxTogReg <= !auxTogReg;
            end
        end
    end

    // Main side: take the held word once the toggle arrives
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reqSync1Reg <= 1'b0;
            reqSync2Reg <= 1'b0;
            ackTogReg <= 1'b0;
            mirrorReg <= 16'h0000;
        end
        else
        begin
            reqSync1Reg <= auxTogReg;
            reqSync2Reg <= reqSync1Reg;
            if (reqSync2Reg != ackTogReg)
            begin
                mirrorReg <= auxHoldReg;
                ackTogReg <= reqSync2Reg;
            end
        end
    end

    // ---------------------------------------------------------------
    // Auxiliary domain: settings sync, wire mode, read grant
    // ---------------------------------------------------------------
    wire auxInRange = auxRdAddr >= AUX_OUT_FIRST && auxRdAddr <= AUX_OUT_LAST;
    wire auxMayRead = !toAux2Reg[2] || toAux2Reg[1];

    // Independent level bits, two flops each
    always_ff @(posedge auxClk)
    begin
        if (!auxRst_n)
        begin
            toAux1Reg <= 3'h0;
            toAux2Reg <= 3'h0;
            auxWireThree <= 1'b0;
            auxRdGrant <= 1'b0;
        end
        else
        begin
            toAux1Reg <= toAuxLevels;
            toAux2Reg <= toAux1Reg;
            auxWireThree <= toAux2Reg[0];
            auxRdGrant <= auxRdStrobe && auxInRange && auxMayRead;
        end
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    ready_override_a: assert property (@(posedge clk) disable iff (!rst_n)
        intEff[SINT_READY_BIT] |=> secondPinOut == $past(stabDataReady))
        else $error("second pin not following stabilization ready");
    route_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        !intEff[SINT_READY_BIT] && routingReg == 8'h00 |=> !secondPinOut)
        else $error("second pin high with no routing");
    ts_alert_a: assert property (@(posedge clk) disable iff (!rst_n)
        !intEff[SINT_READY_BIT] && routingReg[ROUTE_TS_BIT] && tsNear |=> secondPinOut)
        else $error("timestamp alert missing");
    pulldown_off_a: assert property (@(posedge clk) disable iff (!rst_n)
        busAvbReg[BUSAVB_PDOFF_BIT] |=> !firstPinPulldownOn)
        else $error("pull-down connected while disabled");
    mirror_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        regReq.wr && !primaryCtlFlag |=> $stable(stabIntReg) && $stable(stabCtlReg))
        else $error("mirrored register changed under auxiliary control");
    mirror_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        regReq.rd && regReq.addr == OFS_STAB_CONTROL_ONE && !primaryCtlFlag
        |=> rdData == $past(mirrorReg[7:0]))
        else $error("control read not showing auxiliary copy");
    trim_read_a: assert property (@(posedge clk) disable iff (!rst_n)
        regReq.rd && regReq.addr == OFS_RATE_TRIM_READOUT |=> rdValid && rdData == $past(rateTrim))
        else $error("rate trim readout wrong");
    cmd_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wrCmd |=> syncCmd == $past(regReq.data))
        else $error("sync command not stored");
    accel_run_a: assert property (@(posedge clk) disable iff (!rst_n)
        accelChainRun |-> $past(chainOn) && $past(ctlEff[SCTL_ACCEL_BIT]))
        else $error("accel chain running without both enables");
    low_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        ctlEff[SCTL_LOW_BIT] |=> gyroRange == RANGE_125)
        else $error("lowest range override lost");
    bus_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
        !busIdle |=> !busAvailable [*2])
        else $error("bus available without idle time");
    aux_grant_a: assert property (@(posedge auxClk) disable iff (!auxRst_n)
        auxRdGrant |-> $past(auxInRange) && $past(auxMayRead))
        else $error("auxiliary read granted out of range or disabled");

endmodule : irc_second_interrupt_pin_stab_regs

/* File: dv/irc_host_model.sv */
`timescale 1ns/1ps
module irc_host_model
    import irc_pkg::*;
(
    input wire logic clk, // Main clock
    output irc_req_s regReq // Request to the register port
);
    // ----------------
    // Strobe driver
    // ----------------
    initial regReq = '0;
    // Fixed-zero positions per register
    function automatic logic [7:0] keepMask(input logic [6:0] a);
        return a == OFS_BUS_AVAILABLE_TIME_CFG ? BUSAVB_MASK :
            a == OFS_STAB_INTERRUPT_CFG ? SINT_MASK :
            a == OFS_STAB_CONTROL_ONE ? SCTL_MASK : 8'hff;
    endfunction : keepMask
    // One-cycle strobe; idle lines then show the inverse, never a stale copy
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{addr: a, wr: w, rd: !w, data: d & keepMask(a)};
        @(posedge clk);
        regReq <= '{addr: ~a, wr: 1'b0, rd: 1'b0, data: ~d};
    endtask : xfer
endmodule : irc_host_model

/* File: dv/second_interrupt_pin_routing_and_ois_ctrl_regs_test.sv */
`timescale 1ns/1ps
module second_interrupt_pin_routing_and_ois_ctrl_regs_test;
    import irc_pkg::*;
    localparam int TSW = 12;
    localparam int AVB [4] = '{50, BUS_AVB_2US_CYC, 200, 400};
    logic clk = 1'b0, auxClk = 1'b0, rst_n = 1'b0, auxRst_n = 1'b0;
    irc_req_s regReq;
    logic [7:0] rdData, syncCmd, syncDelta, d, d2, rateTrim = 8'h00;
    logic [7:0] auxIntCfgCopy = 8'h00, auxCtrlOneCopy = 8'h00;
    logic rdValid, actChange = 1'b0, actStatus = 1'b0, sleepStatusSel = 1'b0;
    logic stabDataReady = 1'b0, primaryCtlFlag = 1'b0, int1RouteAny = 1'b0;
    logic dynAddrAssigned = 1'b0, busIdle = 1'b0, dataGateIn = 1'b0, auxRdStrobe = 1'b0;
    logic secondPinOut, firstPinPulldownOn, busAvailable, gyroGateActive, gyroChainRun;
    logic accelChainRun, lpfDedicated, activityRateChange, auxWireThree, auxRdGrant;
    logic [5:0] eventIn = 6'h00;
    logic [1:0] activityMode = 2'h0;
    logic [1:0] lv;
    logic [TSW-1:0] tsCount = 12'h000;
    logic [6:0] auxRdAddr = 7'h00;
    irc_gate_e gyroGateMode;
    irc_range_e gyroRange;
    logic [7:0] expQ [$];
    logic [31:0] lfsrState = 32'h4363;
    int n_errors = 0, samples_checked = 0, cycles = 0, n;
    logic [6:0] ofs [7] = '{OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING, OFS_SYNC_COMMAND_CODE, OFS_SYNC_DELTA_TIME,
        OFS_BUS_AVAILABLE_TIME_CFG, OFS_RATE_TRIM_READOUT, OFS_STAB_INTERRUPT_CFG,
        OFS_STAB_CONTROL_ONE};
    logic [7:0] wv [7];

    irc_second_interrupt_pin_stab_regs #(.TS_W(TSW), .BUS_AVB_50US_CYC(50), .BUS_AVB_1MS_CYC(200),
        .BUS_AVB_25MS_CYC(400)) i_dut (.clk, .rst_n, .auxClk, .auxRst_n, .regReq, .rdData,
        .rdValid, .eventIn, .actChange, .actStatus, .sleepStatusSel, .activityMode, .tsCount,
        .stabDataReady, .primaryCtlFlag, .int1RouteAny, .dynAddrAssigned, .rateTrim, .busIdle,
        .dataGateIn, .auxIntCfgCopy, .auxCtrlOneCopy, .auxRdAddr, .auxRdStrobe, .secondPinOut,
        .firstPinPulldownOn, .busAvailable, .syncCmd, .syncDelta, .gyroGateActive,
        .gyroGateMode, .gyroChainRun, .accelChainRun, .lpfDedicated, .gyroRange,
        .activityRateChange, .auxWireThree, .auxRdGrant);
    irc_host_model i_host (.clk, .regReq);

    // ----------------
    // Clocks, reset, helpers
    // ----------------
    // Main and link clocks, unrelated in phase
    always #2 clk = ~clk;
    always #62.5 auxClk = ~auxClk;
    // Link domain leaves reset after two of its own edges, settled before the first link check
    initial begin
        repeat (2) @(posedge auxClk);
        auxRst_n <= 1'b1;
    end
    function automatic logic [7:0] rnd();
        lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^ lfsrState[1] ^ lfsrState[0]};
        return lfsrState[7:0];
    endfunction : rnd
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int c);
        repeat (c) @(posedge clk);
    endtask : tick
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        i_host.xfer(a, 1'b1, v);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        expQ.push_back(e);
        i_host.xfer(a, 1'b0, 8'h00);
    endtask : rd
    // Drives the six events and the selected activity source, the other inverted
    task automatic evs(input logic [6:0] ev);
        @(posedge clk);
        eventIn <= ev[5:0];
        actChange <= ev[6] ^ sleepStatusSel;
        actStatus <= ev[6] ^ !sleepStatusSel;
        tick(3);
    endtask : evs
    task automatic auxRd(input logic [6:0] a, input logic e);
        @(posedge auxClk);
        auxRdAddr <= a;
        auxRdStrobe <= 1'b1;
        @(posedge auxClk);
        auxRdStrobe <= 1'b0;
        auxRdAddr <= ~a;
        @(posedge auxClk);
        chk(auxRdGrant, e);
    endtask : auxRd
    task automatic test_done;
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    // Read results are matched against the oldest noted value
    always @(posedge clk)
        if (rdValid === 1'b1)
            chk(rdData, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
    // Hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            $display("CHECK FAILED %0t run did not finish", $time);
            test_done();
        end
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        tick(10);
        rst_n <= 1'b1;
        rateTrim <= rnd();
        chk(gyroGateMode, GATE_OFF);
        chk(gyroRange, RANGE_250);
        foreach (ofs[i]) rd(ofs[i], ofs[i] == OFS_RATE_TRIM_READOUT ? rateTrim : 8'h00);
        rd(7'h64, 8'h00);
        @(posedge clk) primaryCtlFlag <= 1'b1;
        foreach (ofs[i])
        begin
            wv[i] = rnd();
            wr(ofs[i], wv[i]);
            rd(ofs[i], ofs[i] == OFS_RATE_TRIM_READOUT ? rateTrim : wv[i] & i_host.keepMask(ofs[i]));
        end
        chk(syncCmd, wv[1]);
        chk(syncDelta, wv[2]);
        for (int k = 0; k < 8; k++)
        begin
            d = rnd();
            d[3:1] = k[2:0];
            d[6] = k[1] ^ k[2];
            d2 = rnd();
            d2[6] = k[0];
            dataGateIn <= d2[0];
            wr(OFS_STAB_INTERRUPT_CFG, d2);
            wr(OFS_STAB_CONTROL_ONE, d);
            tick(100);
            lv = {d[SCTL_LVL1_BIT], d2[SINT_LVL2_BIT]};
            chk(gyroRange, d[SCTL_LOW_BIT] ? RANGE_125 : 5'h02 << d[3:2]);
            chk(gyroGateMode, lv == 2'h2 ? GATE_TRIG : lv == 2'h3 ? GATE_LATCH : GATE_OFF);
            chk(gyroGateActive, d2[SINT_POL_BIT] ? d2[0] : !d2[0]);
            chk({gyroChainRun, accelChainRun, lpfDedicated}, {d[0], d[0] & d[4], d[0]});
            chk(auxWireThree, d[SCTL_WIRE_BIT]);
        end
        @(posedge clk) primaryCtlFlag <= 1'b0;
        @(posedge auxClk)
        begin
            auxIntCfgCopy <= 8'h88;
            auxCtrlOneCopy <= 8'h35;
        end
        tick(400);
        rd(OFS_STAB_INTERRUPT_CFG, 8'h88);
        rd(OFS_STAB_CONTROL_ONE, 8'h35);
        auxRd(AUX_OUT_FIRST, 1'b1);
        wr(OFS_STAB_INTERRUPT_CFG, 8'h00);
        wr(OFS_STAB_CONTROL_ONE, 8'h00);
        tick(4);
        chk({gyroRange, accelChainRun, lpfDedicated, auxWireThree}, {RANGE_500, 3'h5});
        @(posedge clk) primaryCtlFlag <= 1'b1;
        rd(OFS_STAB_INTERRUPT_CFG, d2 & SINT_MASK);
        rd(OFS_STAB_CONTROL_ONE, d & SCTL_MASK);
        wr(OFS_STAB_INTERRUPT_CFG, 8'h00);
        for (int i = 1; i < 8; i++)
        begin
            @(posedge clk) sleepStatusSel <= i[0];
            wr(OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING, 8'h01 << i);
            evs(~(7'h01 << (i - 1)));
            chk(secondPinOut, 8'h00);
            evs(7'h01 << (i - 1));
            chk(secondPinOut, 8'h01);
        end
        wr(OFS_STAB_INTERRUPT_CFG, 8'h80);
        tick(3);
        chk(secondPinOut, 8'h00);
        @(posedge clk) stabDataReady <= 1'b1;
        evs(7'h00);
        chk(secondPinOut, 8'h01);
        wr(OFS_STAB_INTERRUPT_CFG, 8'h00);
        wr(OFS_SECOND_INTERRUPT_PIN_EVENT_ROUTING, 8'h01);
        for (int i = 0; i < 2; i++)
        begin
            @(posedge clk) tsCount <= 12'hefe + i;
            tick(3);
            chk(secondPinOut, i);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(OFS_BUS_AVAILABLE_TIME_CFG, {6'h00, i[1:0] ^ 2'h1} << 3 | i[0]);
            int1RouteAny <= i[1];
            dynAddrAssigned <= i[2];
            tick(3);
            chk(firstPinPulldownOn, !i[0] && (!i[1] || i[2]));
            activityMode <= i[1:0];
            tick(3);
            chk(activityRateChange, i[1:0] != 2'h0);
        end
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_BUS_AVAILABLE_TIME_CFG, s[1:0] << 3);
            busIdle <= 1'b0;
            tick(3);
            chk(busAvailable, 8'h00);
            busIdle <= 1'b1;
            n = 0;
            while (busAvailable !== 1'b1 && n < 2000)
            begin
                @(posedge clk);
                n++;
            end
            chk(n >= AVB[s] && n <= AVB[s] + 4, 8'h01);
        end
        for (int e = 0; e < 2; e++)
        begin
            wr(OFS_STAB_INTERRUPT_CFG, e << SINT_RDEN_BIT);
            tick(100);
            auxRd(7'h21, 1'b0);
            auxRd(AUX_OUT_FIRST, e);
            auxRd(AUX_OUT_LAST, e);
            auxRd(7'h2e, 1'b0);
        end
        chk(expQ.size(), 8'h00);
        test_done();
    end
endmodule : second_interrupt_pin_routing_and_ois_ctrl_regs_test
